// >>> core/cwc_cache.sv
// Four-way set-associative cache controller with write-back buffer and array windows
`timescale 1ns/1ps

module cwc_cache (
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  input  wire logic                        cpu_req,
  input  wire logic                        cpu_we,
  input  wire logic                        cpu_ifetch,
  input  wire logic [cwc_pkg::ADDR_W-1:0]  cpu_addr,
  input  wire logic [cwc_pkg::DATA_W-1:0]  cpu_wdata,
  output logic                             cpu_busy,
  output logic                             cpu_done,
  output logic                             cpu_err,
  output logic [cwc_pkg::DATA_W-1:0]       cpu_rdata,
  input  wire logic [cwc_pkg::REG_AW-1:0]  reg_addr,
  input  wire logic [cwc_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic [cwc_pkg::DATA_W-1:0]       reg_rdata,
  output logic                             mem_req,
  output logic                             mem_we,
  output logic [cwc_pkg::ADDR_W-1:0]       mem_addr,
  output logic [cwc_pkg::DATA_W-1:0]       mem_wdata,
  input  wire logic [cwc_pkg::DATA_W-1:0]  mem_rdata,
  input  wire logic                        mem_ack
);
  import cwc_pkg::*;

  // Lowest matching way wins
  function automatic logic [WAY_W-1:0] way_enc(input logic [NUM_WAYS-1:0] v);
    return v[0] ? 2'h0 : v[1] ? 2'h1 : v[2] ? 2'h2 : v[3] ? 2'h3 : 2'h0;
  endfunction

  function automatic logic [WAY_W-1:0] lru_victim(input logic [LRU_W-1:0] l);
    logic [WAY_W-1:0] r;
    r = 2'h3;
    if (l[5] && l[4] && l[3]) r = 2'h0;
    else if (!l[5] && l[2] && l[1]) r = 2'h1;
    else if (!l[4] && !l[2] && l[0]) r = 2'h2;
    return r;
  endfunction

  // Each bit orders one pair of ways; a set bit marks the lower way as older
  function automatic logic [LRU_W-1:0] lru_mru(input logic [LRU_W-1:0] cur, input logic [WAY_W-1:0] w);
    logic [LRU_W-1:0] n;
    case (w)
      2'h0: n = {3'h0, cur[2:0]};
      2'h1: n = {1'h1, cur[4:3], 2'h0, cur[0]};
      2'h2: n = {cur[5], 1'h1, cur[3], 1'h1, cur[1], 1'h0};
      default: n = {cur[5:4], 1'h1, cur[2], 2'h3};
    endcase
    return n;
  endfunction

  // Tags and data stay unreset; only flags and LRU live in resettable flops
  logic [TAG_W-1:0]    tag_mem  [0:NUM_WAYS-1][0:NUM_SETS-1];
  logic [DATA_W-1:0]   data_mem [0:NUM_WAYS-1][0:NUM_SETS*WORDS-1];
  logic [NUM_SETS-1:0] ok_ff    [0:NUM_WAYS-1];
  logic [NUM_SETS-1:0] mod_ff   [0:NUM_WAYS-1];
  logic [LRU_W-1:0]    lru_ff   [0:NUM_SETS-1];

  cwc_state_t          state_ff;
  cwc_state_t          nxt_state;
  logic                req_we_ff;
  logic                req_if_ff;
  logic [ADDR_W-1:0]   req_addr_ff;
  logic [DATA_W-1:0]   req_wdata_ff;
  logic [WAY_W-1:0]    fill_way_ff;
  logic [WORD_W-1:0]   beat_ff;
  logic                cache_on_ff;
  logic                low_pol_ff;
  logic                p1_pol_ff;
  logic                wb_full_ff;
  logic                drain_act_ff;
  logic [WORD_W-1:0]   drain_cnt_ff;
  logic [LINE_W-1:0]   wb_line_ff;
  logic [DATA_W-1:0]   wb_data_ff [0:WORDS-1];
  logic                mem_req_ff;
  logic                own_drain_ff;
  logic                mem_we_ff;
  logic [ADDR_W-1:0]   mem_addr_ff;
  logic [DATA_W-1:0]   mem_wdata_ff;
  logic                cpu_done_ff;
  logic                cpu_err_ff;
  logic [DATA_W-1:0]   cpu_rdata_ff;
  logic [DATA_W-1:0]   reg_rdata_ff;

  logic                look_done;
  logic                look_rhit;
  logic                look_whit;
  logic                look_to_fill;
  logic                look_wb_load;

  wire [SET_W-1:0]     set_idx    = req_addr_ff[SET_MSB:SET_LSB];
  wire [WORD_W-1:0]    word_idx   = req_addr_ff[WORD_MSB:WORD_LSB];
  wire [DIDX_W-1:0]    didx       = {set_idx, word_idx};
  wire [TAG_W-1:0]     line_tag   = req_addr_ff[TAG_MSB:TAG_LSB];
  wire [TAG_W-1:0]     mm_tag     = req_wdata_ff[TAG_MSB:TAG_LSB];
  wire [WAY_W-1:0]     mm_way     = req_addr_ff[MM_WAY_MSB:MM_WAY_LSB];
  wire                 mm_assoc   = req_addr_ff[MM_ASSOC_BIT];
  wire [2:0]           region     = req_addr_ff[ADDR_W-1:REGION_LSB];
  wire                 in_tag_win = req_addr_ff[ADDR_W-1:WIN_LSB] == TAG_WIN_TOP;
  wire                 in_dat_win = req_addr_ff[ADDR_W-1:WIN_LSB] == DATA_WIN_TOP;
  wire                 in_win     = in_tag_win || in_dat_win;
  wire                 cacheable  = cache_on_ff && (!region[2] || region == REGION_P1 || region == REGION_P3);
  wire                 wb_policy  = (region == REGION_P1) ? p1_pol_ff : !low_pol_ff;

  logic [NUM_WAYS-1:0] hit_vec;
  logic [NUM_WAYS-1:0] amatch;
  for (genvar g = 0; g < NUM_WAYS; g++) begin : g_way
    assign hit_vec[g] = ok_ff[g][set_idx] && (tag_mem[g][set_idx] == line_tag);
    assign amatch[g]  = tag_mem[g][set_idx] == mm_tag;
  end

  wire                 hit       = |hit_vec;
  wire [WAY_W-1:0]     hit_way   = way_enc(hit_vec);
  wire [WAY_W-1:0]     am_way    = way_enc(amatch);
  wire [LRU_W-1:0]     cur_lru   = lru_ff[set_idx];
  wire [WAY_W-1:0]     victim    = lru_victim(cur_lru);
  wire                 vic_dirty = ok_ff[victim][set_idx] && mod_ff[victim][set_idx];

  wire                 mm_ok     = (state_ff == S_LOOK) && in_win && !req_if_ff;
  wire                 tag_wr    = mm_ok && in_tag_win && req_we_ff;
  wire                 tag_dwr   = tag_wr && !mm_assoc;
  wire                 tag_awr   = tag_wr && mm_assoc && (|amatch);
  wire                 dat_wr    = mm_ok && in_dat_win && req_we_ff;
  wire [DATA_W-1:0]    tag_word  = {3'h0, tag_mem[mm_way][set_idx], lru_ff[set_idx], 2'h0,
                                    mod_ff[mm_way][set_idx], ok_ff[mm_way][set_idx]};

  wire                 fsm_ack   = mem_ack && mem_req_ff && !own_drain_ff;
  wire                 drain_ack = mem_ack && mem_req_ff && own_drain_ff;
  wire                 fill_wr   = (state_ff == S_FILL) && fsm_ack;
  wire                 fill_last = fill_wr && (beat_ff == 2'h3);
  wire                 fill_fwd  = fill_wr && !req_we_ff && (beat_ff == word_idx);
  wire [DATA_W-1:0]    fill_word = (req_we_ff && beat_ff == word_idx) ? req_wdata_ff : mem_rdata;
  wire                 ext_ack   = (state_ff == S_EXT) && fsm_ack;

  wire                 ctl_wr    = reg_wr && (reg_addr == REG_CTL_OFS);
  wire                 purge     = ctl_wr && reg_wdata[CTL_PURGE_BIT];

  // Bus is granted to the line fill or uncached cycle unless a drain already owns it
  wire                 fsm_need  = (state_ff == S_FILL || state_ff == S_EXT) && !drain_act_ff;
  wire                 launch    = !mem_req_ff && (fsm_need || drain_act_ff);
  wire                 drain_go  = wb_full_ff && !drain_act_ff && (state_ff == S_IDLE);
  wire [ADDR_W-1:0]    fsm_addr  = (state_ff == S_FILL) ? {req_addr_ff[ADDR_W-1:LINE_LSB], beat_ff, 2'h0} : req_addr_ff;

  always_comb begin
    nxt_state    = state_ff;
    look_done    = 1'h0;
    look_rhit    = 1'h0;
    look_whit    = 1'h0;
    look_to_fill = 1'h0;
    look_wb_load = 1'h0;
    case (state_ff)
      S_IDLE: begin
        if (cpu_req) nxt_state = S_LOOK;
      end
      S_LOOK: begin
        if (in_win) begin
          look_done = 1'h1;
          nxt_state = S_IDLE;
        end else if (!cacheable) begin
          nxt_state = S_EXT;
        end else if (hit && !req_we_ff) begin
          look_rhit = 1'h1;
          look_done = 1'h1;
          nxt_state = S_IDLE;
        end else if (hit) begin
          look_whit = 1'h1;
          look_done = wb_policy;
          nxt_state = wb_policy ? S_IDLE : S_EXT;
        end else if (req_we_ff && !wb_policy) begin
          nxt_state = S_EXT;
        end else if (!(vic_dirty && wb_full_ff)) begin
          look_to_fill = 1'h1;
          look_wb_load = vic_dirty;
          nxt_state    = S_FILL;
        end
      end
      S_FILL: begin
        if (fill_last) nxt_state = S_IDLE;
      end
      S_EXT: begin
        if (fsm_ack) nxt_state = S_IDLE;
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (look_whit) data_mem[hit_way][didx] <= req_wdata_ff;
    if (dat_wr) data_mem[mm_way][didx] <= req_wdata_ff;
    if (fill_wr) data_mem[fill_way_ff][{set_idx, beat_ff}] <= fill_word;
    if (fill_last) tag_mem[fill_way_ff][set_idx] <= line_tag;
    if (tag_dwr) tag_mem[mm_way][set_idx] <= mm_tag;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int w = 0; w < NUM_WAYS; w++) begin
        ok_ff[w]  <= '0;
        mod_ff[w] <= '0;
      end
      for (int s = 0; s < NUM_SETS; s++) lru_ff[s] <= '0;
    end else if (purge) begin
      for (int w = 0; w < NUM_WAYS; w++) begin
        ok_ff[w]  <= '0;
        mod_ff[w] <= '0;
      end
      for (int s = 0; s < NUM_SETS; s++) lru_ff[s] <= '0;
    end else begin
      if (look_rhit || look_whit) lru_ff[set_idx] <= lru_mru(cur_lru, hit_way);
      if (look_whit && wb_policy) mod_ff[hit_way][set_idx] <= 1'h1;
      if (look_to_fill) ok_ff[victim][set_idx] <= 1'h0;
      if (fill_last) begin
        ok_ff[fill_way_ff][set_idx]  <= 1'h1;
        mod_ff[fill_way_ff][set_idx] <= req_we_ff;
        lru_ff[set_idx]              <= lru_mru(cur_lru, fill_way_ff);
      end
      if (tag_dwr) begin
        ok_ff[mm_way][set_idx]  <= req_wdata_ff[TD_OK_BIT];
        mod_ff[mm_way][set_idx] <= req_wdata_ff[TD_MOD_BIT];
        lru_ff[set_idx]         <= req_wdata_ff[TD_LRU_MSB:TD_LRU_LSB];
      end
      if (tag_awr) begin
        ok_ff[am_way][set_idx]  <= req_wdata_ff[TD_OK_BIT];
        mod_ff[am_way][set_idx] <= req_wdata_ff[TD_MOD_BIT];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff     <= S_IDLE;
      req_we_ff    <= 1'h0;
      req_if_ff    <= 1'h0;
      req_addr_ff  <= '0;
      req_wdata_ff <= '0;
      fill_way_ff  <= 2'h0;
      beat_ff      <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == S_IDLE && cpu_req) begin
        req_we_ff    <= cpu_we;
        req_if_ff    <= cpu_ifetch;
        req_addr_ff  <= cpu_addr;
        req_wdata_ff <= cpu_wdata;
      end
      if (look_to_fill) fill_way_ff <= victim;
      if (look_to_fill) beat_ff <= 2'h0;
      else if (fill_wr) beat_ff <= beat_ff + 2'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_done_ff  <= 1'h0;
      cpu_err_ff   <= 1'h0;
      cpu_rdata_ff <= '0;
    end else begin
      cpu_done_ff <= look_done || fill_fwd || (fill_last && req_we_ff) || ext_ack;
      cpu_err_ff  <= look_done && in_win && req_if_ff;
      if (look_rhit) cpu_rdata_ff <= data_mem[hit_way][didx];
      else if (mm_ok && !req_we_ff) cpu_rdata_ff <= in_tag_win ? tag_word : data_mem[mm_way][didx];
      else if (fill_fwd || (ext_ack && !req_we_ff)) cpu_rdata_ff <= mem_rdata;
    end
  end

  // Single-line buffer: a second dirty victim waits in lookup until it empties
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_full_ff   <= 1'h0;
      drain_act_ff <= 1'h0;
      drain_cnt_ff <= 2'h0;
      wb_line_ff   <= '0;
      for (int i = 0; i < WORDS; i++) wb_data_ff[i] <= '0;
    end else begin
      if (look_wb_load) begin
        wb_full_ff <= 1'h1;
        wb_line_ff <= {3'h0, tag_mem[victim][set_idx], set_idx[LINE_SET_W-1:0]};
        for (int i = 0; i < WORDS; i++) wb_data_ff[i] <= data_mem[victim][{set_idx, i[WORD_W-1:0]}];
      end else if (drain_ack && drain_cnt_ff == 2'h3) begin
        wb_full_ff <= 1'h0;
      end
      if (drain_go) drain_act_ff <= 1'h1;
      else if (drain_ack && drain_cnt_ff == 2'h3) drain_act_ff <= 1'h0;
      if (drain_go) drain_cnt_ff <= 2'h0;
      else if (drain_ack) drain_cnt_ff <= drain_cnt_ff + 2'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_req_ff   <= 1'h0;
      own_drain_ff <= 1'h0;
      mem_we_ff    <= 1'h0;
      mem_addr_ff  <= '0;
      mem_wdata_ff <= '0;
    end else if (launch) begin
      mem_req_ff   <= 1'h1;
      own_drain_ff <= !fsm_need;
      mem_we_ff    <= fsm_need ? (req_we_ff && state_ff == S_EXT) : 1'h1;
      mem_addr_ff  <= fsm_need ? fsm_addr : {wb_line_ff, drain_cnt_ff, 2'h0};
      mem_wdata_ff <= fsm_need ? req_wdata_ff : wb_data_ff[drain_cnt_ff];
    end else if (mem_ack && mem_req_ff) begin
      mem_req_ff <= 1'h0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cache_on_ff  <= CTL_RESET;
      low_pol_ff   <= CTL_RESET;
      p1_pol_ff    <= CTL_RESET;
      reg_rdata_ff <= '0;
    end else begin
      if (ctl_wr) begin
        cache_on_ff <= reg_wdata[CTL_ON_BIT];
        low_pol_ff  <= reg_wdata[CTL_LOW_BIT];
        p1_pol_ff   <= reg_wdata[CTL_P1_BIT];
      end
      reg_rdata_ff <= '0;
      if (reg_rd && reg_addr == REG_CTL_OFS) reg_rdata_ff <= {29'h0, p1_pol_ff, low_pol_ff, cache_on_ff};
      else if (reg_rd && reg_addr == REG_STAT_OFS) reg_rdata_ff <= {29'h0, cpu_busy, drain_act_ff, wb_full_ff};
    end
  end

  assign cpu_busy  = state_ff != S_IDLE;
  assign cpu_done  = cpu_done_ff;
  assign cpu_err   = cpu_err_ff;
  assign cpu_rdata = cpu_rdata_ff;
  assign reg_rdata = reg_rdata_ff;
  assign mem_req   = mem_req_ff;
  assign mem_we    = mem_we_ff;
  assign mem_addr  = mem_addr_ff;
  assign mem_wdata = mem_wdata_ff;
endmodule

// >>> core/cwc_pkg.sv
// Shared constants and types for the four-way cache controller
package cwc_pkg;
  localparam int ADDR_W       = 32;
  localparam int DATA_W       = 32;
  localparam int NUM_WAYS     = 4;
  localparam int NUM_SETS     = 256;
  localparam int WORDS        = 4;
  localparam int SET_W        = 8;
  localparam int WAY_W        = 2;
  localparam int WORD_W       = 2;
  localparam int TAG_W        = 19;
  localparam int LRU_W        = 6;
  localparam int LINE_W       = 28;
  localparam int DIDX_W       = SET_W + WORD_W;
  localparam int REG_AW       = 8;

  // CPU address fields
  localparam int SET_LSB      = 4;
  localparam int SET_MSB      = 11;
  localparam int WORD_LSB     = 2;
  localparam int WORD_MSB     = 3;
  localparam int TAG_LSB      = 10;
  localparam int TAG_MSB      = 28;
  localparam int LINE_LSB     = 4;
  localparam int LINE_SET_W   = 6;
  localparam int REGION_LSB   = 29;
  localparam int WIN_LSB      = 24;

  // Memory-mapped array windows and their address fields
  localparam logic [7:0] TAG_WIN_TOP  = 8'hf0;
  localparam logic [7:0] DATA_WIN_TOP = 8'hf1;
  localparam int MM_WAY_LSB   = 12;
  localparam int MM_WAY_MSB   = 13;
  localparam int MM_ASSOC_BIT = 3;

  // Tag-array data word fields
  localparam int TD_LRU_LSB   = 4;
  localparam int TD_LRU_MSB   = 9;
  localparam int TD_MOD_BIT   = 1;
  localparam int TD_OK_BIT    = 0;

  // Cacheable regions by address bits 31:29
  localparam logic [2:0] REGION_P1 = 3'h4;
  localparam logic [2:0] REGION_P3 = 3'h6;

  // Register port map
  localparam logic [REG_AW-1:0] REG_CTL_OFS  = 8'h00;
  localparam logic [REG_AW-1:0] REG_STAT_OFS = 8'h04;
  localparam int CTL_ON_BIT    = 0;
  localparam int CTL_LOW_BIT   = 1;
  localparam int CTL_P1_BIT    = 2;
  localparam int CTL_PURGE_BIT = 3;
  localparam logic CTL_RESET   = 1'h0;

  typedef enum logic [1:0] {S_IDLE, S_LOOK, S_FILL, S_EXT} cwc_state_t;
endpackage

// >>> verif/cwc_monitor.sv
// Port checker for the four-way cache controller
`timescale 1ns/1ps
module cwc_monitor (
  input wire logic                       ref_clk,
  input wire logic                       rst_n,
  input wire logic                       cpu_req,
  input wire logic                       cpu_ifetch,
  input wire logic [cwc_pkg::ADDR_W-1:0] cpu_addr,
  input wire logic                       cpu_busy,
  input wire logic                       cpu_done,
  input wire logic                       cpu_err,
  input wire logic [cwc_pkg::REG_AW-1:0] reg_addr,
  input wire logic                       reg_rd,
  input wire logic [cwc_pkg::DATA_W-1:0] reg_rdata,
  input wire logic                       mem_req,
  input wire logic                       mem_we,
  input wire logic [cwc_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [cwc_pkg::DATA_W-1:0] mem_wdata,
  input wire logic                       mem_ack
);
  import cwc_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_TAKE: assert property (cpu_req && !cpu_busy |=> cpu_busy)
    else $error("request not taken");
  AST_WIN_FETCH: assert property (cpu_req && !cpu_busy && cpu_ifetch && cpu_addr[31:24] == TAG_WIN_TOP
    |-> ##2 cpu_done && cpu_err) else $error("fetch from tag window not refused");
  AST_ERR_DONE: assert property (cpu_err |-> cpu_done)
    else $error("error without done");
  AST_BEAT_HOLD: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
    && $stable(mem_we) && $stable(mem_wdata)) else $error("beat changed before ack");
  AST_BEAT_END: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("beat held after ack");
  AST_LONGWORD: assert property (mem_req |-> mem_addr[1:0] == 2'h0)
    else $error("beat not longword aligned");
  AST_PURGE_ZERO: assert property (reg_rd && reg_addr == REG_CTL_OFS |=> !reg_rdata[CTL_PURGE_BIT])
    else $error("purge bit read as one");
  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data outside read cycle");
endmodule
bind cwc_cache cwc_monitor u_mon (.ref_clk, .rst_n, .cpu_req, .cpu_ifetch, .cpu_addr, .cpu_busy, .cpu_done,
  .cpu_err, .reg_addr, .reg_rd, .reg_rdata, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack);

// >>> verif/cwc_mem_model.sv
// External memory model answering the controller's bus beats
`timescale 1ns/1ps
module cwc_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  input  wire logic [7:0]  ack_dly,
  output logic [31:0]      mem_rdata,
  output logic             mem_ack
);
  logic [7:0] cnt_ff;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 8'h0;
      mem_ack <= 1'h0;
      mem_rdata <= 32'h0;
    end else if (mem_req && !mem_ack && cnt_ff >= ack_dly) begin
      mem_ack <= 1'h1;
      mem_rdata <= mem_addr ^ 32'h5a5a_0000;
      cnt_ff <= 8'h0;
    end else begin
      mem_ack <= 1'h0;
      // Toggle so stale data never passes for a match
      mem_rdata <= ~mem_rdata;
      cnt_ff <= mem_req ? cnt_ff + 8'h1 : 8'h0;
    end
  end
endmodule

// >>> verif/tb_top.sv
// Self-checking testbench for the four-way cache controller
`timescale 1ns/1ps
module tb_top;
  import cwc_pkg::*;
  localparam logic [31:0] KEY = 32'h5a5a_0000;
  localparam logic [31:0] L1  = 32'h0000_1230;
  localparam logic [31:0] L3  = 32'h0000_5230;
  localparam logic [7:0]  S   = 8'h23;
  logic        ref_clk, rst_n, cpu_req, cpu_we, cpu_ifetch, reg_wr, reg_rd, err;
  logic        cpu_busy, cpu_done, cpu_err, mem_req, mem_we, mem_ack;
  logic [31:0] cpu_addr, cpu_wdata, cpu_rdata, reg_wdata, reg_rdata;
  logic [31:0] mem_addr, mem_wdata, mem_rdata, rd, wr_addr, wr_data;
  logic [7:0]  reg_addr, ack_dly;
  int          n_errors, checked, nrd, nwr, rd_at_wr, lat;

  cwc_cache dut (.ref_clk, .rst_n, .cpu_req, .cpu_we, .cpu_ifetch, .cpu_addr, .cpu_wdata, .cpu_busy,
    .cpu_done, .cpu_err, .cpu_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mem_req,
    .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack);
  cwc_mem_model mem (.ref_clk, .rst_n, .mem_req, .mem_addr, .ack_dly, .mem_rdata, .mem_ack);

  initial begin
    ref_clk = 1'h0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Beat log; order of first write against reads shows refill priority
  always @(posedge ref_clk) begin
    if (mem_req && mem_ack && mem_we) begin
      if (nwr == 0) rd_at_wr = nrd;
      nwr++;
      wr_addr = mem_addr;
      wr_data = mem_wdata;
    end else if (mem_req && mem_ack) nrd++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic clr;
    nrd = 0;
    nwr = 0;
    rd_at_wr = -1;
  endtask
  task automatic idle;
    repeat (120) @(posedge ref_clk);
    #1;
  endtask
  function automatic logic [31:0] ta(input logic [1:0] w, input logic [7:0] s, input logic a);
    return {TAG_WIN_TOP, 10'h0, w, s, a, 3'h0};
  endfunction
  function automatic logic [31:0] tw(input logic [18:0] t, input logic [5:0] l, input logic u, v);
    return {3'h0, t, l, 2'h0, u, v};
  endfunction
  task automatic rwr(input logic [7:0] a, input logic [31:0] d);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'h1};
    @(posedge ref_clk);
    #1 reg_wr <= 1'h0;
  endtask
  task automatic rrd(input logic [7:0] a);
    {reg_addr, reg_rd} <= {a, 1'h1};
    @(posedge ref_clk);
    #1 reg_rd <= 1'h0;
    rd = reg_rdata;
  endtask
  task automatic acc(input logic we, fe, input logic [31:0] a, d);
    {cpu_we, cpu_ifetch, cpu_addr, cpu_wdata, cpu_req} <= {we, fe, a, d, 1'h1};
    @(posedge ref_clk);
    #1 cpu_req <= 1'h0;
    lat = 0;
    while (cpu_done !== 1'h1 && lat < 500) begin
      @(posedge ref_clk);
      #1 lat++;
    end
    rd = cpu_rdata;
    err = cpu_err;
    while (cpu_busy !== 1'h0 && lat < 500) begin
      @(posedge ref_clk);
      #1;
    end
    if (lat >= 500) chk(32'h0, 32'h1, "no done");
  endtask

  task automatic t_init;
    rrd(REG_CTL_OFS);
    chk(rd, 32'h0, "ctl reset");
    rrd(8'h10);
    chk(rd, 32'h0, "unmapped read");
    for (int w = 0; w < 4; w++) begin
      acc(1'h0, 1'h0, ta(w[1:0], S, 1'h0), '0);
      chk({rd[9:4], rd[1:0]}, 32'h0, "flags at reset");
      acc(1'h1, 1'h0, ta(w[1:0], S, 1'h0), tw(19'h7ff00, 6'h0, 1'h0, 1'h0));
    end
    $display("t_init done");
  endtask
  task automatic t_miss;
    rwr(REG_CTL_OFS, 32'h1);
    clr;
    acc(1'h0, 1'h0, L1 + 32'h4, '0);
    chk(nrd, 4, "fill beats");
    chk(rd, (L1 + 32'h4) ^ KEY, "forwarded word");
    acc(1'h0, 1'h0, ta(2'h3, S, 1'h1), '0);
    chk({rd[28:10], rd[1:0]}, {L1[28:10], 2'h1}, "way 3 filled");
    clr;
    acc(1'h0, 1'h1, L1 + 32'h8, '0);
    chk(nrd + lat, 1, "hit latency");
    chk(rd, (L1 + 32'h8) ^ KEY, "hit word");
    clr;
    acc(1'h1, 1'h0, L1 + 32'hc, 32'hcafe_0001);
    chk(nrd + nwr, 0, "no external cycle");
    acc(1'h0, 1'h0, L1 + 32'hc, '0);
    chk(rd, 32'hcafe_0001, "written word");
    acc(1'h0, 1'h0, ta(2'h3, S, 1'h0), '0);
    chk(rd[1:0], 2'h3, "modified set");
    $display("t_miss done");
  endtask
  task automatic t_dirty;
    acc(1'h1, 1'h0, ta(2'h0, S, 1'h0), tw(19'h00abc, 6'h3f, 1'h1, 1'h1));
    for (int k = 0; k < 4; k++)
      acc(1'h1, 1'h0, {DATA_WIN_TOP, 10'h0, 2'h0, S, k[1:0], 2'h0}, 32'hd000_0000 + k);
    // Slow memory keeps the drain open while the hit is tried
    ack_dly <= 8'h6;
    clr;
    acc(1'h0, 1'h0, L3, '0);
    chk(rd, L3 ^ KEY, "miss word");
    acc(1'h0, 1'h0, L1, '0);
    chk(lat, 1, "hit while draining");
    rrd(REG_STAT_OFS);
    chk(rd, 32'h3, "buffer full and draining");
    idle;
    chk(rd_at_wr, 4, "refill before drain");
    chk(nwr, 4, "one line drained");
    chk(wr_addr, {3'h0, 19'h00abc, S[5:0], 4'hc}, "drain address");
    chk(wr_data, 32'hd000_0003, "drain data");
    acc(1'h0, 1'h0, ta(2'h0, S, 1'h0), '0);
    chk({rd[28:10], rd[1:0]}, {L3[28:10], 2'h1}, "way 0 refilled");
    ack_dly <= 8'h1;
    acc(1'h1, 1'h0, ta(2'h1, S, 1'h1), tw(19'h00777, 6'h0, 1'h0, 1'h0));
    acc(1'h0, 1'h0, ta(2'h3, S, 1'h0), '0);
    chk(rd[1:0], 2'h3, "no match no change");
    acc(1'h1, 1'h0, ta(2'h1, S, 1'h1), tw(L3[28:10], 6'h0, 1'h0, 1'h0));
    acc(1'h0, 1'h0, ta(2'h0, S, 1'h0), '0);
    chk({rd[28:10], rd[1:0]}, {L3[28:10], 2'h0}, "match clears flags");
    $display("t_dirty done");
  endtask
  task automatic t_policy;
    rwr(REG_CTL_OFS, 32'h3);
    clr;
    acc(1'h1, 1'h0, L1, 32'hbeef_0002);
    chk(nwr + nrd, 1, "one write beat");
    chk(wr_data, 32'hbeef_0002, "write data");
    acc(1'h0, 1'h0, L1, '0);
    chk(rd, 32'hbeef_0002, "cache updated");
    acc(1'h0, 1'h0, ta(2'h3, S, 1'h0), '0);
    chk(rd[1:0], 2'h3, "modified kept");
    clr;
    acc(1'h1, 1'h0, 32'h0000_9230, 32'h1);
    acc(1'h1, 1'h0, 32'h8000_0400, 32'h2);
    chk(nwr * 8 + nrd, 16, "write-through misses");
    clr;
    acc(1'h0, 1'h0, 32'h0000_9230, '0);
    chk(nrd, 4, "miss not allocated");
    acc(1'h1, 1'h0, 32'h0000_9230, 32'h4);
    acc(1'h0, 1'h0, ta(2'h1, S, 1'h0), '0);
    chk(rd[1:0], 2'h1, "clean hit stays clean");
    idle;
    rwr(REG_CTL_OFS, 32'h5);
    clr;
    acc(1'h1, 1'h0, 32'h8000_0800, 32'h3);
    acc(1'h0, 1'h0, 32'h8000_0800, '0);
    chk(nwr * 8 + nrd, 4, "write miss allocates");
    chk(rd, 32'h3, "merged word");
    $display("t_policy done");
  endtask
  task automatic t_purge;
    rwr(REG_CTL_OFS, 32'h9);
    rrd(REG_CTL_OFS);
    chk(rd, 32'h1, "purge reads 0");
    clr;
    acc(1'h0, 1'h0, ta(2'h3, 8'h80, 1'h0), '0);
    idle;
    chk({rd[9:4], rd[1:0], 8'(nwr)}, 32'h0, "purged, no write-back");
    acc(1'h0, 1'h1, ta(2'h0, S, 1'h0), '0);
    chk(err, 1'h1, "fetch from tag window");
    clr;
    acc(1'h0, 1'h0, 32'hc000_0100, '0);
    chk(nrd, 4, "upper region cached");
    clr;
    acc(1'h0, 1'h0, 32'ha000_0100, '0);
    rwr(REG_CTL_OFS, 32'h0);
    acc(1'h0, 1'h0, L1, '0);
    chk(nrd, 2, "uncached single beats");
    $display("t_purge done");
  endtask

  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    #500_000;
    n_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_of_test;
  end

  initial begin
    {rst_n, cpu_req, cpu_we, cpu_ifetch, reg_wr, reg_rd} = '0;
    {cpu_addr, cpu_wdata, reg_wdata, reg_addr} = '0;
    ack_dly = 8'h1;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'h1;
    t_init;
    t_miss;
    t_dirty;
    t_policy;
    t_purge;
    end_of_test;
  end
endmodule
